// ---- design/rtcc_cfg.svh ----
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH

`define RTCC_CLK_PERIOD_NS 25
`define RTCC_TICK_NS 3906250
`define RTCC_TICK_CYCLES (`RTCC_TICK_NS / `RTCC_CLK_PERIOD_NS)
`define RTCC_SW_STEP_NS 10000000
`define RTCC_SW_STEP_CYCLES (`RTCC_SW_STEP_NS / `RTCC_CLK_PERIOD_NS)

`define RTCC_REG_CTRL 2'h0
`define RTCC_REG_SWCTL 2'h1
`define RTCC_REG_FLAG 2'h2
`define RTCC_REG_ENABLE 2'h3

`define RTCC_CTL_TRIM_BUSY 15
`define RTCC_CTL_TRIM_MSB 14
`define RTCC_CTL_TRIM_LSB 8
`define RTCC_CTL_BUSY 6
`define RTCC_CTL_HOLD 5
`define RTCC_CTL_H24 4
`define RTCC_CTL_ADJ 2
`define RTCC_CTL_RST 1
`define RTCC_CTL_RUN 0
`define RTCC_CTL_RESET 16'h0000

`define RTCC_SW_TENTH_LSB 12
`define RTCC_SW_HUND_LSB 8
`define RTCC_SW_CLEAR 4
`define RTCC_SW_RUN 0

`define RTCC_F_32 0
`define RTCC_F_EIGHTH 1
`define RTCC_F_QUARTER 2
`define RTCC_F_HALF 3
`define RTCC_F_SEC 4
`define RTCC_F_MIN 5
`define RTCC_F_HOUR 6
`define RTCC_F_DAY 7
`define RTCC_F_ALARM 8
`define RTCC_F_SW100 9
`define RTCC_F_SW10 10
`define RTCC_F_SW1 11
`define RTCC_F_TRIM 12

`define RTCC_TRIM_DONE_AT 8'h7F
`define RTCC_BCD_MAX 4'h9

`endif

// ---- design/rtcc_pkg.sv ----
package rtcc_pkg;

  typedef logic [12:0] rtcc_flags_t;

  typedef struct packed {
    logic one_hz;
    logic ten_hz;
    logic hundred_hz;
  } rtcc_swev_s;

  typedef struct packed {
    logic [19:0] pre;
    logic [3:0]  hund;
    logic [3:0]  tenth;
    rtcc_swev_s  ev;
  } rtcc_sw_s;

  typedef struct packed {
    logic [23:0] tick_cnt;
    logic [7:0]  divider;
    logic [4:0]  pend;
    logic        pend_alarm;
    logic        alarm_q;
    logic        run;
    logic        hour24;
    logic        hold;
    logic        missed;
    logic        busy;
    logic        adj;
    logic [1:0]  adj_cnt;
    logic        rst_busy;
    logic        trim_busy;
    logic [6:0]  trim_val;
    rtcc_flags_t flags;
    rtcc_flags_t enables;
    logic        sw_run;
    logic [15:0] rdata;
    logic        irq;
    logic        sec_out;
    logic        adj_out;
    logic        trim_apply;
  } rtcc_state_s;

endpackage

// ---- design/rtcc_stopwatch.sv ----
`timescale 1ns/1ps
`include "rtcc_cfg.svh"
module rtcc_stopwatch #(
  parameter int STEP_CYCLES = `RTCC_SW_STEP_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               run,
  input  wire logic               clear,
  output rtcc_pkg::rtcc_swev_s    ev,
  output logic [3:0]              tenths,
  output logic [3:0]              hundredths
);

  rtcc_pkg::rtcc_sw_s st;
  rtcc_pkg::rtcc_sw_s next_st;
  logic               step;

  always_comb begin
    next_st = st;
    next_st.ev = '0;
    step = run && (st.pre == 20'(STEP_CYCLES - 1));
    if (run) begin
      next_st.pre = step ? 20'h00000 : st.pre + 20'h00001;
    end
    // hundredths carry into tenths, tenths carry out as 1 Hz
    if (step) begin
      next_st.ev.hundred_hz = 1'b1;
      if (st.hund == `RTCC_BCD_MAX) begin
        next_st.hund = 4'h0;
        next_st.ev.ten_hz = 1'b1;
        if (st.tenth == `RTCC_BCD_MAX) begin
          next_st.tenth = 4'h0;
          next_st.ev.one_hz = 1'b1;
        end else begin
          next_st.tenth = st.tenth + 4'h1;
        end
      end else begin
        next_st.hund = st.hund + 4'h1;
      end
    end
    // a clear while running keeps counting from zero
    if (clear) begin
      next_st.pre = 20'h00000;
      next_st.hund = 4'h0;
      next_st.tenth = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ev = st.ev;
  assign tenths = st.tenth;
  assign hundredths = st.hund;

  a_bcd_range: assert property (
    @(posedge clk) disable iff (!rstn)
    st.hund <= `RTCC_BCD_MAX && st.tenth <= `RTCC_BCD_MAX)
    else $error("stopwatch digit out of bcd range");

  a_tenth_carry: assert property (
    @(posedge clk) disable iff (!rstn)
    st.ev.ten_hz |-> st.ev.hundred_hz && st.hund == 4'h0)
    else $error("tenths event without hundredths wrap");
endmodule

// ---- design/rtcc_top.sv ----
`timescale 1ns/1ps
`include "rtcc_cfg.svh"
// Overview of operation
// - hundredths bcd counter feeds tenths bcd counter
// - alarm match sets sticky alarm flag
// - day, hour, minute, second count-ups set flags
// - stopwatch 1, 10, 100 hz flags
// - trim end sets trim done flag
// - divider events raised one tick later
// - alarm event raised one tick after match
// - interrupt only for enabled set flags
// - trim write sets trim busy, self clears only while the calendar runs
// - trim field bits 14-8, reads zero
// - trim writes ignored while trim busy
// - count-up busy high for one tick
// - hold freezes count-up, one catch-up second
// - hold forced low while trim busy
// - bit 4 selects 24-hour hour range
// - adjust bit runs half-minute correction, self clears
// - reset bit clears divider, adjust, hold
// - reset bit returns to zero when done
// - run bit stops and resumes counting
module rtcc_top #(
  parameter int TICK_CYCLES    = `RTCC_TICK_CYCLES,
  parameter int SW_STEP_CYCLES = `RTCC_SW_STEP_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic [1:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  output logic             IRQ,
  input  wire logic        ALARM_MATCH,
  input  wire logic        MINUTE_CARRY,
  input  wire logic        HOUR_CARRY,
  input  wire logic        DAY_CARRY,
  output logic             SECOND_COUNTUP,
  output logic             ADJUST_START,
  output logic             TRIM_APPLY,
  output logic      [6:0]  TRIM_VALUE,
  output logic             HOUR_FORMAT_SEL,
  output logic             CALENDAR_RUN
);

  rtcc_pkg::rtcc_state_s st;
  rtcc_pkg::rtcc_state_s next_st;
  rtcc_pkg::rtcc_flags_t ev;
  rtcc_pkg::rtcc_swev_s  sw_ev;
  logic [3:0]            sw_tenths;
  logic [3:0]            sw_hund;
  logic                  sw_clear;
  logic                  tick;
  logic                  countup;
  logic [7:0]            new_div;
  logic [7:0]            fell;
  logic [6:0]            trim_in;

  function automatic logic hit(input logic       strobe,
                               input logic [1:0] addr,
                               input logic [1:0] reg_idx);
    return strobe && (addr == reg_idx);
  endfunction

  rtcc_stopwatch #(
    .STEP_CYCLES (SW_STEP_CYCLES)
  ) u_stopwatch (
    .clk        (CLK),
    .rstn       (RSTN),
    .run        (st.sw_run),
    .clear      (sw_clear),
    .ev         (sw_ev),
    .tenths     (sw_tenths),
    .hundredths (sw_hund)
  );

  assign trim_in = WDATA[`RTCC_CTL_TRIM_MSB:`RTCC_CTL_TRIM_LSB];

  always_comb begin
    next_st = st;
    ev = '0;
    countup = 1'b0;
    sw_clear = 1'b0;
    new_div = st.divider;
    fell = 8'h00;
    next_st.sec_out = 1'b0;
    next_st.adj_out = 1'b0;
    next_st.trim_apply = 1'b0;
    next_st.rdata = 16'h0000;
    tick = (st.tick_cnt == 24'(TICK_CYCLES - 1));
    next_st.tick_cnt = tick ? 24'h000000 : st.tick_cnt + 24'h000001;

    // the 1/256 s tick: fire what the previous tick queued
    if (tick) begin
      ev[`RTCC_F_SEC] = st.pend[4];
      ev[`RTCC_F_HALF] = st.pend[3];
      ev[`RTCC_F_QUARTER] = st.pend[2];
      ev[`RTCC_F_EIGHTH] = st.pend[1];
      ev[`RTCC_F_32] = st.pend[0];
      ev[`RTCC_F_ALARM] = st.pend_alarm;
      next_st.pend = 5'h00;
      next_st.pend_alarm = 1'b0;
      next_st.busy = 1'b0;
      next_st.rst_busy = 1'b0;
      // divider frozen while stopped or mid reset
      if (st.run && !st.rst_busy) begin
        new_div = st.divider + 8'h01;
        fell = st.divider & ~new_div;
        next_st.pend = {fell[7], fell[6], fell[5], fell[4], fell[2]};
        if (fell[7]) begin
          if (st.hold) begin
            next_st.missed = 1'b1;
          end else begin
            countup = 1'b1;
          end
        end
        // trim lands as the divider reaches 0x7F
        if (st.trim_busy && new_div == `RTCC_TRIM_DONE_AT) begin
          next_st.trim_busy = 1'b0;
          next_st.trim_apply = 1'b1;
          ev[`RTCC_F_TRIM] = 1'b1;
        end
      end
      next_st.divider = new_div;
      // correction works even with the clock stopped
      if (st.adj) begin
        next_st.adj_cnt = st.adj_cnt + 2'h1;
        if (st.adj_cnt == 2'h0) begin
          next_st.adj_out = 1'b1;
          next_st.busy = 1'b1;
          ev[`RTCC_F_SEC] = 1'b1;
        end else begin
          next_st.adj = 1'b0;
        end
      end
    end

    // a match edge queues the alarm for the next tick
    if (ALARM_MATCH && !st.alarm_q) begin
      next_st.pend_alarm = 1'b1;
    end
    next_st.alarm_q = ALARM_MATCH;

    ev[`RTCC_F_MIN] = MINUTE_CARRY;
    ev[`RTCC_F_HOUR] = HOUR_CARRY;
    ev[`RTCC_F_DAY] = DAY_CARRY;
    ev[`RTCC_F_SW100] = sw_ev.hundred_hz;
    ev[`RTCC_F_SW10] = sw_ev.ten_hz;
    ev[`RTCC_F_SW1] = sw_ev.one_hz;

    if (hit(WR, ADDR, `RTCC_REG_CTRL)) begin
      next_st.hour24 = WDATA[`RTCC_CTL_H24];
      next_st.run = WDATA[`RTCC_CTL_RUN];
      // zero trim field means no trim request
      if (!st.trim_busy && trim_in != 7'h00) begin
        next_st.trim_busy = 1'b1;
        next_st.trim_val = trim_in;
      end
      next_st.hold = WDATA[`RTCC_CTL_HOLD] && !st.trim_busy;
      // several missed seconds still give one catch-up second
      if (st.hold && !WDATA[`RTCC_CTL_HOLD] && next_st.missed) begin
        countup = 1'b1;
        next_st.missed = 1'b0;
      end
      if (WDATA[`RTCC_CTL_ADJ] && !st.adj) begin
        next_st.adj = 1'b1;
        next_st.adj_cnt = 2'h0;
      end
      if (WDATA[`RTCC_CTL_RST]) begin
        next_st.rst_busy = 1'b1;
        next_st.divider = 8'h00;
        next_st.pend = 5'h00;
        next_st.adj = 1'b0;
        next_st.hold = 1'b0;
        next_st.missed = 1'b0;
      end
    end
    if (next_st.trim_busy) begin
      next_st.hold = 1'b0;
    end
    if (countup) begin
      next_st.sec_out = 1'b1;
      next_st.busy = 1'b1;
    end

    if (hit(WR, ADDR, `RTCC_REG_SWCTL)) begin
      next_st.sw_run = WDATA[`RTCC_SW_RUN];
      sw_clear = WDATA[`RTCC_SW_CLEAR];
    end

    // set wins over a same-cycle clear
    if (hit(WR, ADDR, `RTCC_REG_FLAG)) begin
      next_st.flags = (st.flags & ~WDATA[12:0]) | ev;
    end else begin
      next_st.flags = st.flags | ev;
    end
    if (hit(WR, ADDR, `RTCC_REG_ENABLE)) begin
      next_st.enables = WDATA[12:0];
    end
    next_st.irq = |(next_st.flags & next_st.enables);

    if (RD) begin
      unique case (ADDR)
        `RTCC_REG_CTRL: begin
          // trim field is write-only and reads as zero
          next_st.rdata[`RTCC_CTL_TRIM_BUSY] = st.trim_busy;
          next_st.rdata[`RTCC_CTL_BUSY] = st.busy;
          next_st.rdata[`RTCC_CTL_HOLD] = st.hold;
          next_st.rdata[`RTCC_CTL_H24] = st.hour24;
          next_st.rdata[`RTCC_CTL_ADJ] = st.adj;
          next_st.rdata[`RTCC_CTL_RST] = st.rst_busy;
          next_st.rdata[`RTCC_CTL_RUN] = st.run;
        end
        `RTCC_REG_SWCTL: begin
          // both digits sampled in the same cycle; a reader compares two reads
          next_st.rdata[15:12] = sw_tenths;
          next_st.rdata[11:8] = sw_hund;
          next_st.rdata[`RTCC_SW_RUN] = st.sw_run;
        end
        `RTCC_REG_FLAG: begin
          next_st.rdata[12:0] = st.flags;
        end
        `RTCC_REG_ENABLE: begin
          next_st.rdata[12:0] = st.enables;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA = st.rdata;
  assign IRQ = st.irq;
  assign SECOND_COUNTUP = st.sec_out;
  assign ADJUST_START = st.adj_out;
  assign TRIM_APPLY = st.trim_apply;
  assign TRIM_VALUE = st.trim_val;
  assign HOUR_FORMAT_SEL = st.hour24;
  assign CALENDAR_RUN = st.run;

  a_trim_reads_zero: assert property (
    @(posedge CLK) disable iff (!RSTN)
    hit(RD, ADDR, `RTCC_REG_CTRL) |=> RDATA[14:8] == 7'h00)
    else $error("trim field read back nonzero");

  a_trim_sets_busy: assert property (
    @(posedge CLK) disable iff (!RSTN)
    hit(WR, ADDR, `RTCC_REG_CTRL) && !st.trim_busy && trim_in != 7'h00
    |=> st.trim_busy && st.trim_val == $past(trim_in))
    else $error("trim write did not set trim busy");

  a_trim_ignored: assert property (
    @(posedge CLK) disable iff (!RSTN)
    st.trim_busy && hit(WR, ADDR, `RTCC_REG_CTRL)
    |=> st.trim_val == $past(st.trim_val))
    else $error("trim value changed while busy");

  a_hold_forced: assert property (
    @(posedge CLK) disable iff (!RSTN)
    st.trim_busy |-> !st.hold)
    else $error("hold set during trim");

  a_alarm_sticky: assert property (
    @(posedge CLK) disable iff (!RSTN)
    st.flags[`RTCC_F_ALARM] && !hit(WR, ADDR, `RTCC_REG_FLAG)
    |=> st.flags[`RTCC_F_ALARM])
    else $error("alarm flag dropped without clear");

  a_set_wins: assert property (
    @(posedge CLK) disable iff (!RSTN)
    hit(WR, ADDR, `RTCC_REG_FLAG)
    |=> (st.flags & $past(ev)) == $past(ev))
    else $error("event lost to clear");

  a_irq_gating: assert property (
    @(posedge CLK) disable iff (!RSTN)
    ##1 IRQ == |($past(next_st.flags) & $past(next_st.enables)))
    else $error("irq does not follow enabled flags");

  a_alarm_delay: assert property (
    @(posedge CLK) disable iff (!RSTN)
    st.pend_alarm && tick |=> st.flags[`RTCC_F_ALARM] && !st.pend_alarm)
    else $error("alarm not raised at tick");

  a_busy_one_tick: assert property (
    @(posedge CLK) disable iff (!RSTN)
    st.busy && tick && !countup && !(st.adj && st.adj_cnt == 2'h0)
    |=> !st.busy)
    else $error("count-up busy outlived its tick");

  a_adj_clears: assert property (
    @(posedge CLK) disable iff (!RSTN)
    st.adj && tick && st.adj_cnt == 2'h1 && !WR |=> !st.adj)
    else $error("adjust bit stuck after two ticks");

  a_rst_done: assert property (
    @(posedge CLK) disable iff (!RSTN)
    st.rst_busy && tick && !WR |=> !st.rst_busy && st.divider == 8'h00)
    else $error("divider reset did not finish");

  a_rst_clears: assert property (
    @(posedge CLK) disable iff (!RSTN)
    hit(WR, ADDR, `RTCC_REG_CTRL) && WDATA[`RTCC_CTL_RST]
    |=> st.rst_busy && !st.adj && !st.hold && st.divider == 8'h00)
    else $error("reset bit did not clear state");

  a_run_stops: assert property (
    @(posedge CLK) disable iff (!RSTN)
    !st.run && !WR |=> st.divider == $past(st.divider))
    else $error("divider moved while stopped");

  a_held_no_second: assert property (
    @(posedge CLK) disable iff (!RSTN)
    st.hold && !WR |=> !SECOND_COUNTUP)
    else $error("second count-up while held");

  a_catch_up: assert property (
    @(posedge CLK) disable iff (!RSTN)
    hit(WR, ADDR, `RTCC_REG_CTRL) && st.hold && st.missed
    && !WDATA[`RTCC_CTL_HOLD] |=> SECOND_COUNTUP && st.busy && !st.missed)
    else $error("missed second not caught up");

  a_trim_done: assert property (
    @(posedge CLK) disable iff (!RSTN)
    tick && st.trim_busy && st.run && !st.rst_busy
    && (st.divider + 8'h01) == `RTCC_TRIM_DONE_AT
    |=> TRIM_APPLY && !st.trim_busy && st.flags[`RTCC_F_TRIM])
    else $error("trim did not complete");

  a_second_wrap: assert property (
    @(posedge CLK) disable iff (!RSTN)
    tick && st.run && !st.rst_busy && !st.hold && st.divider == 8'hFF
    |=> SECOND_COUNTUP && st.busy)
    else $error("divider wrap gave no count-up");

  a_second_event: assert property (
    @(posedge CLK) disable iff (!RSTN)
    tick && st.pend[4] |=> st.flags[`RTCC_F_SEC])
    else $error("second event not raised at tick");
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam int TK = 8;
  localparam int SW = 4;
  logic        CLK;
  logic        RSTN;
  logic [1:0]  ADDR;
  logic [15:0] WDATA;
  logic        WR;
  logic        RD;
  logic [15:0] RDATA;
  logic        IRQ;
  logic        ALARM_MATCH;
  logic [2:0]  car;
  logic        SECOND_COUNTUP;
  logic        ADJUST_START;
  logic        TRIM_APPLY;
  logic [6:0]  TRIM_VALUE;
  logic        HOUR_FORMAT_SEL;
  logic        CALENDAR_RUN;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] h;
  int          c;
  int          i;
  int          err_count;
  int          compares;

  rtcc_top #(.TICK_CYCLES(TK), .SW_STEP_CYCLES(SW)) dut (
    .CLK             (CLK),
    .RSTN            (RSTN),
    .ADDR            (ADDR),
    .WDATA           (WDATA),
    .WR              (WR),
    .RD              (RD),
    .RDATA           (RDATA),
    .IRQ             (IRQ),
    .ALARM_MATCH     (ALARM_MATCH),
    .MINUTE_CARRY    (car[0]),
    .HOUR_CARRY      (car[1]),
    .DAY_CARRY       (car[2]),
    .SECOND_COUNTUP  (SECOND_COUNTUP),
    .ADJUST_START    (ADJUST_START),
    .TRIM_APPLY      (TRIM_APPLY),
    .TRIM_VALUE      (TRIM_VALUE),
    .HOUR_FORMAT_SEL (HOUR_FORMAT_SEL),
    .CALENDAR_RUN    (CALENDAR_RUN)
  );

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  task automatic pulse(input int k);
    @(posedge CLK);
    car <= 3'h1 << k;
    @(posedge CLK);
    car <= 3'h0;
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? SECOND_COUNTUP : ((s == 1) ? ADJUST_START : TRIM_APPLY);
  endfunction

  // control readback: chosen hour format plus the given status bits
  function automatic logic [15:0] ctl_exp(input logic [15:0] bits);
    return h | bits;
  endfunction

  // counts one-cycle pulses; stop returns at the first one seen
  task automatic watch(input int n, input int s, input bit stop,
                       output int cnt);
    cnt = 0;
    repeat (n) begin
      #1;
      if (pick(s) === 1'b1) cnt++;
      if (stop && cnt > 0) return;
      @(posedge CLK);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge CLK);
    err_count++;
    end_of_test();
  end

  initial begin
    err_count = 0;
    compares = 0;
    RSTN = 1'b0;
    ADDR = 2'h0;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
    ALARM_MATCH = 1'b0;
    car = 3'h0;
    c = $urandom(94879);
    h = ($urandom & 1) ? 16'h0010 : 16'h0000;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rd(i[1:0], v);
      chk("reset_value", v, 16'h0000);
    end
    for (i = 0; i < 4; i++) begin
      w = 16'($urandom);
      wr(2'h3, w);
      rd(2'h3, v);
      chk("enable_reg", v, w & 16'h1FFF);
    end
    wr(2'h3, 16'h0000);
    for (i = 0; i < 3; i++) begin
      pulse(i);
      rd(2'h2, v);
      chk("carry_flag", v, 16'h0020 << i);
      chk("irq_masked", {15'h0, IRQ}, 16'h0000);
      wr(2'h2, v);
    end
    wr(2'h3, 16'h0020);
    pulse(0);
    repeat (2) @(posedge CLK);
    #1 chk("irq_enabled", {15'h0, IRQ}, 16'h0001);
    // clear and new event in one cycle
    @(posedge CLK);
    ADDR  <= 2'h2;
    WDATA <= 16'h0020;
    WR    <= 1'b1;
    car   <= 3'h1;
    @(posedge CLK);
    WR  <= 1'b0;
    car <= 3'h0;
    rd(2'h2, v);
    chk("race_flag", v, 16'h0020);
    wr(2'h2, 16'h0020);
    rd(2'h2, v);
    chk("flag_clear", v, 16'h0000);
    chk("irq_gone", {15'h0, IRQ}, 16'h0000);
    wr(2'h3, 16'h0000);
    // adjust while the calendar is stopped
    wr(2'h0, h | 16'h0004);
    // start pulse can come one cycle after the write, so watch first
    watch(3 * TK, 1, 1, c);
    chk("adjust_start", c[15:0], 16'h0001);
    rd(2'h0, v);
    chk("adjust_set", v & 16'h0004, 16'h0004);
    repeat (3 * TK) @(posedge CLK);
    rd(2'h0, v);
    chk("adjust_done", v, ctl_exp(16'h0000));
    chk("hour_format", {15'h0, HOUR_FORMAT_SEL}, h >> 4);
    rd(2'h2, v);
    chk("adjust_event", v, 16'h0010);
    wr(2'h2, v);
    wr(2'h0, h | 16'h2A01);
    rd(2'h0, v);
    chk("trim_busy", v, ctl_exp(16'h8001));
    wr(2'h0, h | 16'h5521);
    rd(2'h0, v);
    chk("trim_locked", v, ctl_exp(16'h8001));
    chk("run_on", {15'h0, CALENDAR_RUN}, 16'h0001);
    watch(300 * TK, 2, 1, c);
    chk("trim_apply", c[15:0], 16'h0001);
    rd(2'h0, v);
    chk("trim_idle", v & 16'hFF20, 16'h0000);
    chk("trim_value", {9'h0, TRIM_VALUE}, 16'h002A);
    rd(2'h2, v);
    chk("trim_flag", v & 16'h1000, 16'h1000);
    watch(300 * TK, 0, 1, c);
    chk("countup", c[15:0], 16'h0001);
    rd(2'h0, v);
    chk("busy_on", v & 16'h0040, 16'h0040);
    repeat (2 * TK) @(posedge CLK);
    rd(2'h0, v);
    chk("busy_off", v & 16'h0040, 16'h0000);
    rd(2'h2, v);
    chk("divider_flags", v & 16'h001F, 16'h001F);
    wr(2'h0, h | 16'h0021);
    watch(260 * TK, 0, 0, c);
    chk("held", c[15:0], 16'h0000);
    wr(2'h0, h | 16'h0001);
    watch(4, 0, 0, c);
    chk("catch_up", c[15:0], 16'h0001);
    // align to the tick so the reset bit is read before it ends
    watch(300 * TK, 0, 1, c);
    // half a second on, so a divider left uncleared would wrap in view
    repeat (128 * TK) @(posedge CLK);
    wr(2'h0, h | 16'h0003);
    rd(2'h0, v);
    chk("reset_bit", v & 16'h0002, 16'h0002);
    repeat (2 * TK) @(posedge CLK);
    rd(2'h0, v);
    chk("reset_done", v, ctl_exp(16'h0001));
    watch(250 * TK, 0, 0, c);
    chk("divider_cleared", c[15:0], 16'h0000);
    wr(2'h2, 16'h1FFF);
    @(posedge CLK);
    ALARM_MATCH <= 1'b1;
    repeat (3 * TK) @(posedge CLK);
    rd(2'h2, v);
    chk("alarm_flag", v & 16'h0100, 16'h0100);
    wr(2'h2, 16'h0100);
    rd(2'h2, v);
    chk("alarm_clear", v & 16'h0100, 16'h0000);
    @(posedge CLK);
    ALARM_MATCH <= 1'b0;
    // stop right after a wrap; a full second must then stay quiet
    watch(300 * TK, 0, 1, c);
    wr(2'h0, h);
    watch(300 * TK, 0, 0, c);
    chk("stopped", c[15:0], 16'h0000);
    // stopwatch start sequence
    wr(2'h1, 16'h0010);
    wr(2'h2, 16'h0E00);
    wr(2'h3, 16'h0800);
    wr(2'h1, 16'h0001);
    repeat (SW * 100 + 20) @(posedge CLK);
    rd(2'h2, v);
    chk("sw_flags", v & 16'h0E00, 16'h0E00);
    chk("sw_irq", {15'h0, IRQ}, 16'h0001);
    // each new read is compared with the one before it
    c = 0;
    rd(2'h1, w);
    do begin
      v = w;
      rd(2'h1, w);
      c++;
    end while (v !== w && c < 8);
    chk("sw_stable", v, w);
    chk("sw_bcd", {15'h0, v[15:12] <= 4'h9 && v[11:8] <= 4'h9
                   && v[7:0] === 8'h01}, 16'h0001);
    wr(2'h1, 16'h0010);
    rd(2'h1, v);
    chk("sw_cleared", v, 16'h0000);
    end_of_test();
  end
endmodule
